// ===== rtl/mpr_miim_bank.sv
`timescale 1ns/1ps
`default_nettype none
module mpr_miim_bank #(
	parameter logic [15:0] ID_HIGH = 16'h1a2b, // arbitrary value
	parameter logic [15:0] ID_LOW = 16'h3c4d // arbitrary value
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mdc, // management clock pin, sampled
	input wire logic mdioIn, // data pin level
	output logic mdioOut,
	output logic mdioOe, // high while driving the data pin
	input wire logic centerSideMode,
	input wire logic [1:0] anComplete,
	input wire logic [1:0] linkUp,
	input wire logic farEndFault, // port 1 only
	input wire logic [4:0] partnerAbil1, // pause,100F,100H,10F,10H
	input wire logic [4:0] partnerAbil2,
	input wire logic [6:0] mapAddr,
	input wire logic mapWrEn,
	input wire logic [7:0] mapWrData,
	output logic [7:0] mapRdData,
	output logic [1:0] force100,
	output logic [1:0] anEnable,
	output logic [1:0] powerDown,
	output logic [1:0] restartAn,
	output logic [1:0] fullDuplex,
	output logic [1:0] forceMdi,
	output logic [1:0] mdixDisable,
	output logic farEndDisable,
	output logic [1:0] txDisable,
	output logic [1:0] ledDisable,
	output logic [1:0] advPause,
	output logic [3:0] advAbil1,
	output logic [3:0] advAbil2
);
	// per-port mirrored bytes: A holds AN enable/speed/duplex/advert, B the rest
	logic [7:0] ctlA_q [2];
	logic [7:0] ctlB_q [2];
	logic [4:0] phyAddr_q; // center-mode address of port 1
	logic [7:0] mapRdData_q;
	// pin synchronisers; stage 1 is only read by stage 2
	logic mdcSync1_q, mdcSync2_q, mdcPrev_q;
	logic mdioSync1_q, mdioSync2_q;
	// frame engine
	mpr_pkg::mpr_state_type state_q;
	logic [5:0] cnt_q;
	logic [12:0] hdr_q;
	logic [15:0] shift_q;
	logic [4:0] regAddr_q;
	logic isRead_q, hit_q, idx_q;
	logic mdioOut_q, mdioOe_q;
	// combinational helpers
	logic rise, bitIn, hit1, hit2, wrStrobe;
	logic [12:0] hdrNext;
	logic [4:0] hdrPhy;
	logic [15:0] wrWord, rdWord;

	// control word seen on the management side
	function automatic logic [15:0] ctlWord(input logic [7:0] a,
		input logic [7:0] b);
		logic [15:0] w;
		w = 16'h0000; // loopback, reset, isolate read 0
		w[mpr_pkg::CTL_SPEED] = a[mpr_pkg::A_SPEED];
		w[mpr_pkg::CTL_AN_EN] = a[mpr_pkg::A_AN_EN];
		w[mpr_pkg::CTL_PWRDN] = b[mpr_pkg::B_PWRDN];
		w[mpr_pkg::CTL_RESTART] = b[mpr_pkg::B_RESTART];
		w[mpr_pkg::CTL_DUPLEX] = a[mpr_pkg::A_DUPLEX];
		w[mpr_pkg::CTL_MDI] = b[mpr_pkg::B_MDI];
		w[mpr_pkg::CTL_NO_MDIX] = b[mpr_pkg::B_MDIX];
		w[mpr_pkg::CTL_NO_FEF] = b[mpr_pkg::B_FEF];
		w[mpr_pkg::CTL_NO_TX] = b[mpr_pkg::B_TX];
		w[mpr_pkg::CTL_NO_LED] = b[mpr_pkg::B_LED];
		return w;
	endfunction

	// advertisement word; selector is constant
	function automatic logic [15:0] advWord(input logic [7:0] a);
		logic [15:0] w;
		w = 16'h0000; // next page and remote fault read 0
		w[mpr_pkg::ADV_PAUSE] = a[mpr_pkg::A_PAUSE];
		w[mpr_pkg::ADV_ABIL_LO +: 4] = a[3:0];
		w[4:0] = mpr_pkg::ADV_SELECTOR;
		return w;
	endfunction

	// partner word laid out like the advertisement word
	function automatic logic [15:0] ptnWord(input logic [4:0] p);
		logic [15:0] w;
		w = 16'h0000;
		w[mpr_pkg::ADV_PAUSE] = p[4];
		w[mpr_pkg::ADV_ABIL_LO +: 4] = p[3:0];
		return w;
	endfunction

	// merge a management control write into the A byte
	function automatic logic [7:0] ctlAFromCtl(input logic [7:0] a,
		input logic [15:0] w);
		logic [7:0] r;
		r = a;
		r[mpr_pkg::A_SPEED] = w[mpr_pkg::CTL_SPEED];
		r[mpr_pkg::A_AN_EN] = w[mpr_pkg::CTL_AN_EN];
		r[mpr_pkg::A_DUPLEX] = w[mpr_pkg::CTL_DUPLEX];
		return r;
	endfunction

	// control write into the B byte, masked per port
	function automatic logic [7:0] ctlBFromCtl(input logic [15:0] w,
		input logic [7:0] mask);
		logic [7:0] r;
		r = 8'h00;
		r[mpr_pkg::B_PWRDN] = w[mpr_pkg::CTL_PWRDN];
		r[mpr_pkg::B_RESTART] = w[mpr_pkg::CTL_RESTART];
		r[mpr_pkg::B_MDI] = w[mpr_pkg::CTL_MDI];
		r[mpr_pkg::B_MDIX] = w[mpr_pkg::CTL_NO_MDIX];
		r[mpr_pkg::B_FEF] = w[mpr_pkg::CTL_NO_FEF];
		r[mpr_pkg::B_TX] = w[mpr_pkg::CTL_NO_TX];
		r[mpr_pkg::B_LED] = w[mpr_pkg::CTL_NO_LED];
		return r & mask;
	endfunction

	// pin sampling and edge finding on the second stage only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mdcSync1_q <= 1'b0;
			mdcSync2_q <= 1'b0;
			mdcPrev_q <= 1'b0;
			mdioSync1_q <= 1'b1;
			mdioSync2_q <= 1'b1;
		end else begin
			mdcSync1_q <= mdc;
			mdcSync2_q <= mdcSync1_q;
			mdcPrev_q <= mdcSync2_q;
			mdioSync1_q <= mdioIn;
			mdioSync2_q <= mdioSync1_q;
		end
	end

	assign rise = mdcSync2_q & ~mdcPrev_q;
	assign bitIn = mdioSync2_q;
	assign hdrNext = {hdr_q[11:0], bitIn};
	assign hdrPhy = hdrNext[mpr_pkg::HDR_PHY_LO +: 5];
	// center mode hides port 2 and moves port 1 to its programmed address
	assign hit1 = centerSideMode ? (hdrPhy == phyAddr_q)
		: (hdrPhy == mpr_pkg::PORT1_ADDR);
	assign hit2 = !centerSideMode && (hdrPhy == mpr_pkg::PORT2_ADDR);
	assign wrWord = {shift_q[14:0], bitIn};
	// commit only for a matched port and an implemented register
	assign wrStrobe = rise && (state_q == mpr_pkg::ST_DATA)
		&& (cnt_q == mpr_pkg::DATA_LAST) && !isRead_q && hit_q
		&& (regAddr_q <= mpr_pkg::LAST_REG);

	// read word of the addressed port and register
	always_comb begin
		case (regAddr_q)
			mpr_pkg::REG_CONTROL: begin
				rdWord = ctlWord(ctlA_q[idx_q], ctlB_q[idx_q]);
			end
			mpr_pkg::REG_STATUS: begin
				rdWord = 16'h0000; // T4, preamble, extended read 0
				rdWord[mpr_pkg::STS_CAPS_LO +: 4] = mpr_pkg::STS_CAPS;
				rdWord[mpr_pkg::STS_AN_DONE] = anComplete[idx_q];
				rdWord[mpr_pkg::STS_FEF] = !idx_q && farEndFault;
				rdWord[mpr_pkg::STS_AN_CAP] =
					ctlA_q[idx_q][mpr_pkg::A_AN_EN];
				rdWord[mpr_pkg::STS_LINK] = linkUp[idx_q];
			end
			mpr_pkg::REG_ID_HIGH: rdWord = ID_HIGH;
			mpr_pkg::REG_ID_LOW: rdWord = ID_LOW;
			mpr_pkg::REG_ADVERT: rdWord = advWord(ctlA_q[idx_q]);
			mpr_pkg::REG_PARTNER: begin
				rdWord = ptnWord(idx_q ? partnerAbil2 : partnerAbil1);
			end
			default: rdWord = 16'h0000;
		endcase
	end

	// frame engine: preamble, header, turnaround, data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= mpr_pkg::ST_PRE;
			cnt_q <= 6'h00;
			hdr_q <= 13'h0000;
			shift_q <= 16'h0000;
			regAddr_q <= 5'h00;
			isRead_q <= 1'b0;
			hit_q <= 1'b0;
			idx_q <= 1'b0;
			mdioOut_q <= 1'b0;
			mdioOe_q <= 1'b0;
		end else if (rise) begin
			case (state_q)
				mpr_pkg::ST_PRE: begin
					// a zero after enough ones is the start bit
					if (bitIn && cnt_q != mpr_pkg::PREAMBLE_ONES) begin
						cnt_q <= cnt_q + 6'h01;
					end else if (!bitIn) begin
						cnt_q <= 6'h00;
						if (cnt_q == mpr_pkg::PREAMBLE_ONES) begin
							state_q <= mpr_pkg::ST_HDR;
						end
					end
				end
				mpr_pkg::ST_HDR: begin
					hdr_q <= hdrNext;
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == mpr_pkg::HDR_LAST) begin
						cnt_q <= 6'h00;
						regAddr_q <= hdrNext[mpr_pkg::HDR_REG_LO +: 5];
						isRead_q <= hdrNext[mpr_pkg::HDR_OP_LO +: 2]
							== mpr_pkg::OP_READ;
						hit_q <= hit1 || hit2;
						idx_q <= hit2;
						// bad start or opcode drops the frame silently
						if (hdrNext[mpr_pkg::HDR_ST] && (hdrNext[
							mpr_pkg::HDR_OP_LO +: 2] == mpr_pkg::OP_READ
							|| hdrNext[mpr_pkg::HDR_OP_LO +: 2]
							== mpr_pkg::OP_WRITE)) begin
							state_q <= mpr_pkg::ST_TA;
						end else begin
							state_q <= mpr_pkg::ST_PRE;
						end
					end
				end
				mpr_pkg::ST_TA: begin
					cnt_q <= cnt_q + 6'h01;
					// unmapped register or port: pin stays released
					if (isRead_q && hit_q
						&& regAddr_q <= mpr_pkg::LAST_REG) begin
						mdioOe_q <= 1'b1;
						mdioOut_q <= 1'b0;
						if (cnt_q == mpr_pkg::TA_LAST) begin
							mdioOut_q <= rdWord[15];
							shift_q <= {rdWord[14:0], 1'b0};
						end
					end
					if (cnt_q == mpr_pkg::TA_LAST) begin
						cnt_q <= 6'h00;
						state_q <= mpr_pkg::ST_DATA;
					end
				end
				mpr_pkg::ST_DATA: begin
					cnt_q <= cnt_q + 6'h01;
					if (isRead_q) begin
						mdioOut_q <= shift_q[15];
						shift_q <= {shift_q[14:0], 1'b0};
					end else begin
						shift_q <= wrWord;
					end
					if (cnt_q == mpr_pkg::DATA_LAST) begin
						cnt_q <= 6'h00;
						mdioOe_q <= 1'b0;
						mdioOut_q <= 1'b0;
						state_q <= mpr_pkg::ST_PRE;
					end
				end
				default: begin
					state_q <= mpr_pkg::ST_PRE;
					cnt_q <= 6'h00;
					mdioOe_q <= 1'b0;
				end
			endcase
		end
	end

	// port bytes; management write beats a map write in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctlA_q[0] <= mpr_pkg::CTL_A_RESET;
			ctlA_q[1] <= mpr_pkg::CTL_A_RESET;
			ctlB_q[0] <= mpr_pkg::CTL_B_RESET;
			ctlB_q[1] <= mpr_pkg::CTL_B_RESET;
			phyAddr_q <= mpr_pkg::PHY_ADDR_RESET;
		end else begin
			// restart is a one-cycle request, so it clears itself
			ctlB_q[0][mpr_pkg::B_RESTART] <= 1'b0;
			ctlB_q[1][mpr_pkg::B_RESTART] <= 1'b0;
			if (mapWrEn) begin
				case (mapAddr)
					mpr_pkg::MAP_P1_CTL_A: ctlA_q[0] <= mapWrData;
					mpr_pkg::MAP_P1_CTL_B: begin
						ctlB_q[0] <= mapWrData & mpr_pkg::CTL_B_MASK_P1;
					end
					mpr_pkg::MAP_P2_CTL_A: ctlA_q[1] <= mapWrData;
					mpr_pkg::MAP_P2_CTL_B: begin
						ctlB_q[1] <= mapWrData & mpr_pkg::CTL_B_MASK_P2;
					end
					mpr_pkg::MAP_PHY_ADDR: phyAddr_q <= mapWrData[4:0];
					default: ; // status bytes are read only
				endcase
			end
			if (wrStrobe && regAddr_q == mpr_pkg::REG_CONTROL) begin
				ctlA_q[idx_q] <= ctlAFromCtl(ctlA_q[idx_q], wrWord);
				ctlB_q[idx_q] <= ctlBFromCtl(wrWord, idx_q
					? mpr_pkg::CTL_B_MASK_P2 : mpr_pkg::CTL_B_MASK_P1);
			end else if (wrStrobe && regAddr_q == mpr_pkg::REG_ADVERT) begin
				ctlA_q[idx_q][mpr_pkg::A_PAUSE] <=
					wrWord[mpr_pkg::ADV_PAUSE];
				ctlA_q[idx_q][3:0] <= wrWord[mpr_pkg::ADV_ABIL_LO +: 4];
			end
		end
	end

	// map read port, one cycle behind the address
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mapRdData_q <= 8'h00;
		end else begin
			case (mapAddr)
				mpr_pkg::MAP_P1_CTL_A: mapRdData_q <= ctlA_q[0];
				mpr_pkg::MAP_P1_CTL_B: mapRdData_q <= ctlB_q[0];
				mpr_pkg::MAP_P1_STS_A: begin
					mapRdData_q <= {1'b0, anComplete[0], linkUp[0],
						partnerAbil1};
				end
				mpr_pkg::MAP_P1_STS_B: begin
					mapRdData_q <= {7'h00, farEndFault};
				end
				mpr_pkg::MAP_P2_CTL_A: mapRdData_q <= ctlA_q[1];
				mpr_pkg::MAP_P2_CTL_B: mapRdData_q <= ctlB_q[1];
				mpr_pkg::MAP_P2_STS_A: begin
					mapRdData_q <= {1'b0, anComplete[1], linkUp[1],
						partnerAbil2};
				end
				mpr_pkg::MAP_PHY_ADDR: mapRdData_q <= {3'h0, phyAddr_q};
				default: mapRdData_q <= 8'h00;
			endcase
		end
	end

	// configuration outputs straight from the port bytes
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			force100[p] = ctlA_q[p][mpr_pkg::A_SPEED];
			anEnable[p] = ctlA_q[p][mpr_pkg::A_AN_EN];
			fullDuplex[p] = ctlA_q[p][mpr_pkg::A_DUPLEX];
			advPause[p] = ctlA_q[p][mpr_pkg::A_PAUSE];
			powerDown[p] = ctlB_q[p][mpr_pkg::B_PWRDN];
			restartAn[p] = ctlB_q[p][mpr_pkg::B_RESTART];
			forceMdi[p] = ctlB_q[p][mpr_pkg::B_MDI];
			mdixDisable[p] = ctlB_q[p][mpr_pkg::B_MDIX];
			txDisable[p] = ctlB_q[p][mpr_pkg::B_TX];
			ledDisable[p] = ctlB_q[p][mpr_pkg::B_LED];
		end
	end

	assign farEndDisable = ctlB_q[0][mpr_pkg::B_FEF];
	assign advAbil1 = ctlA_q[0][3:0];
	assign advAbil2 = ctlA_q[1][3:0];
	assign mapRdData = mapRdData_q;
	assign mdioOut = mdioOut_q;
	assign mdioOe = mdioOe_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_DRIVE_ON_HIT: assert property (
		$rose(mdioOe) |-> hit_q && isRead_q && !mdioOut)
		else $error("data pin driven for a foreign port");
	AST_DRIVE_IMPL_REG: assert property (
		$rose(mdioOe) |-> regAddr_q <= mpr_pkg::LAST_REG)
		else $error("data pin driven for an unsupported register");
	AST_CENTER_PORT1: assert property (
		centerSideMode && wrStrobe |-> !idx_q)
		else $error("port 2 written in center mode");
	AST_FOREIGN_NO_EFFECT: assert property (
		rise && state_q == mpr_pkg::ST_DATA && cnt_q == mpr_pkg::DATA_LAST
		&& !isRead_q && !hit_q && !mapWrEn
		|=> $stable(force100) && $stable(advAbil1) && $stable(anEnable))
		else $error("foreign write changed state");
	AST_SPEED_WRITE: assert property (
		wrStrobe && regAddr_q == mpr_pkg::REG_CONTROL && !idx_q
		|=> force100[0] == $past(wrWord[mpr_pkg::CTL_SPEED]))
		else $error("forced speed not taken from control write");
	AST_RESTART_PULSE: assert property (
		restartAn[0] && !$past(restartAn[0]) |=> !restartAn[0] || wrStrobe)
		else $error("restart request held too long");
	AST_STATUS_CAPS: assert property (
		regAddr_q == mpr_pkg::REG_STATUS |->
		rdWord[15:11] == {1'b0, mpr_pkg::STS_CAPS} && !rdWord[0])
		else $error("status capability bits wrong");
	AST_FEF_PORT2: assert property (
		!ctlB_q[1][mpr_pkg::B_FEF])
		else $error("far-end disable set on port 2");
	AST_RESET_VALUES: assert property (
		$past(sys_rst) |-> anEnable == 2'h3 && advAbil1 == 4'hf
		&& !force100[0] && advPause == 2'h3)
		else $error("wrong values after reset");
	AST_READ_RELEASE: assert property (
		mdioOe && $past(state_q) == mpr_pkg::ST_DATA
		&& state_q == mpr_pkg::ST_PRE |-> 1'b0)
		else $error("data pin still driven after the frame");

	COV_READ: cover property ($rose(mdioOe) ##[1:300] $fell(mdioOe));
	COV_WRITE_CTL: cover property (wrStrobe
		&& regAddr_q == mpr_pkg::REG_CONTROL);
	COV_CENTER_WRITE: cover property (wrStrobe && centerSideMode);
	COV_MAP_WRITE: cover property (mapWrEn
		&& mapAddr == mpr_pkg::MAP_P2_CTL_B);
endmodule
`default_nettype wire

// ===== pkg/mpr_pkg.sv
`default_nettype none
// shared constants of the management register bank
package mpr_pkg;
	// management addresses answered by the two copper ports
	localparam logic [4:0] PORT1_ADDR = 5'h01;
	localparam logic [4:0] PORT2_ADDR = 5'h02;
	localparam logic [4:0] PHY_ADDR_RESET = 5'h01;
	// register addresses inside one port
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_ID_HIGH = 5'h02;
	localparam logic [4:0] REG_ID_LOW = 5'h03;
	localparam logic [4:0] REG_ADVERT = 5'h04;
	localparam logic [4:0] REG_PARTNER = 5'h05;
	localparam logic [4:0] LAST_REG = 5'h05;
	// basic control word bit positions
	localparam int CTL_SPEED = 13;
	localparam int CTL_AN_EN = 12;
	localparam int CTL_PWRDN = 11;
	localparam int CTL_RESTART = 9;
	localparam int CTL_DUPLEX = 8;
	localparam int CTL_MDI = 4;
	localparam int CTL_NO_MDIX = 3;
	localparam int CTL_NO_FEF = 2;
	localparam int CTL_NO_TX = 1;
	localparam int CTL_NO_LED = 0;
	// basic status word bit positions and fixed capabilities
	localparam int STS_CAPS_LO = 11;
	localparam logic [3:0] STS_CAPS = 4'hf;
	localparam int STS_AN_DONE = 5;
	localparam int STS_FEF = 4;
	localparam int STS_AN_CAP = 3;
	localparam int STS_LINK = 2;
	// advertisement and partner word layout
	localparam int ADV_PAUSE = 10;
	localparam int ADV_ABIL_LO = 5;
	localparam logic [4:0] ADV_SELECTOR = 5'h01;
	// byte-wide map indices of the mirrored port registers
	localparam logic [6:0] MAP_P1_CTL_A = 7'h1c;
	localparam logic [6:0] MAP_P1_CTL_B = 7'h1d;
	localparam logic [6:0] MAP_P1_STS_A = 7'h1e;
	localparam logic [6:0] MAP_P1_STS_B = 7'h1f;
	localparam logic [6:0] MAP_P2_CTL_A = 7'h2c;
	localparam logic [6:0] MAP_P2_CTL_B = 7'h2d;
	localparam logic [6:0] MAP_P2_STS_A = 7'h2e;
	localparam logic [6:0] MAP_PHY_ADDR = 7'h40;
	// bit positions inside the mirrored bytes
	localparam int A_AN_EN = 7;
	localparam int A_SPEED = 6;
	localparam int A_DUPLEX = 5;
	localparam int A_PAUSE = 4;
	localparam int B_LED = 7;
	localparam int B_TX = 6;
	localparam int B_RESTART = 5;
	localparam int B_FEF = 4;
	localparam int B_PWRDN = 3;
	localparam int B_MDIX = 2;
	localparam int B_MDI = 1;
	localparam int S_AN_DONE = 6;
	localparam int S_LINK = 5;
	localparam int S_FEF = 0;
	// reset images and writable masks of the mirrored bytes
	localparam logic [7:0] CTL_A_RESET = 8'h9f;
	localparam logic [7:0] CTL_B_RESET = 8'h00;
	localparam logic [7:0] CTL_B_MASK_P1 = 8'hfe;
	localparam logic [7:0] CTL_B_MASK_P2 = 8'hee;
	// management frame layout
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h0c;
	localparam logic [5:0] TA_LAST = 6'h01;
	localparam logic [5:0] DATA_LAST = 6'h0f;
	localparam int HDR_ST = 12;
	localparam int HDR_OP_LO = 10;
	localparam int HDR_PHY_LO = 5;
	localparam int HDR_REG_LO = 0;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [1:0] OP_WRITE = 2'h1;
	// frame engine states, one-hot
	typedef enum logic [3:0] {
		ST_PRE = 4'h1,
		ST_HDR = 4'h2,
		ST_TA = 4'h4,
		ST_DATA = 4'h8
	} mpr_state_type;
endpackage
`default_nettype wire

// ===== sim/mpr_mdio_master.sv
`timescale 1ns/1ps
`default_nettype none
// management master on the far side of the data pin
module mpr_mdio_master (
	input wire logic clk,
	output logic mdc,
	output logic mdioDrv,
	output logic mdioDrvOe,
	input wire logic mdioWire
);
	// clock pin stays low between frames
	initial begin
		mdc = 1'b0;
		mdioDrv = 1'b1;
		mdioDrvOe = 1'b0;
	end

	// half of a 160 ns management clock period
	task automatic halfWait();
		repeat (4) @(negedge clk);
	endtask

	// data changes while the clock is low and is sampled at the rise
	task automatic oneBit(input logic oe, input logic b, output logic s);
		mdioDrvOe = oe;
		mdioDrv = b;
		halfWait();
		mdc = 1'b1;
		s = mdioWire;
		halfWait();
		mdc = 1'b0;
	endtask

	// full frame: fresh preamble, header, turnaround, sixteen data bits
	task automatic frame(input logic [1:0] op, input logic [4:0] phy,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [31:0] bits;
		logic s;
		int i;
		bits = {2'b01, op, phy, ra, 2'b10, wd};
		rd = 16'h0000;
		// a new preamble every time, the device counts it again
		for (i = 0; i < 32; i++) begin
			oneBit(1'b1, 1'b1, s);
		end
		// on a read the pin is released for turnaround and data
		for (i = 31; i >= 0; i--) begin
			oneBit(!(op == mpr_pkg::OP_READ && i < 18), bits[i], s);
			rd = {rd[14:0], s};
		end
		mdioDrvOe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	// clock and reset
	logic clk = 1'b0;
	logic sysRst = 1'b1;
	// shared data pin and its parties
	logic mdc, drv, drvOe, mdioOut, mdioOe, mdioWire;
	// status levels fed to the bank
	logic centerMode = 1'b0;
	logic [1:0] anDone = 2'h0;
	logic [1:0] linkUp = 2'h0;
	logic fef = 1'b0;
	logic [4:0] partner1 = 5'h15;
	logic [4:0] partner2 = 5'h0a;
	// byte map access
	logic [6:0] mapAddr = 7'h00;
	logic mapWrEn = 1'b0;
	logic [7:0] mapWrData = 8'h00;
	logic [7:0] mapRdData;
	// configuration outputs
	logic [1:0] force100, anEnable, powerDown, restartAn, fullDuplex;
	logic [1:0] forceMdi, mdixDisable, txDisable, ledDisable, advPause;
	logic farEndDisable;
	logic [3:0] advAbil1, advAbil2;
	// restart is only a pulse, so it is caught here
	logic sawRestart = 1'b0;
	int failCount = 0;
	int checks = 0;
	localparam logic [15:0] ID_HI = 16'h5a3c; // arbitrary value
	localparam logic [15:0] ID_LO = 16'hc3a5; // arbitrary value

	// 50 MHz clock
	always #10 clk = ~clk;
	// pull-up wins when nobody drives the pin
	assign mdioWire = mdioOe ? mdioOut : (drvOe ? drv : 1'b1);
	// latch the one-cycle restart pulse of port 1
	always @(posedge clk) begin
		if (restartAn[0] === 1'b1) begin
			sawRestart <= 1'b1;
		end
	end

	mpr_miim_bank #(.ID_HIGH(ID_HI), .ID_LOW(ID_LO)) uut (
		.clk(clk), .sys_rst(sysRst), .mdc(mdc), .mdioIn(mdioWire),
		.mdioOut(mdioOut), .mdioOe(mdioOe), .centerSideMode(centerMode),
		.anComplete(anDone), .linkUp(linkUp), .farEndFault(fef),
		.partnerAbil1(partner1), .partnerAbil2(partner2),
		.mapAddr(mapAddr), .mapWrEn(mapWrEn), .mapWrData(mapWrData),
		.mapRdData(mapRdData), .force100(force100), .anEnable(anEnable),
		.powerDown(powerDown), .restartAn(restartAn),
		.fullDuplex(fullDuplex), .forceMdi(forceMdi),
		.mdixDisable(mdixDisable), .farEndDisable(farEndDisable),
		.txDisable(txDisable), .ledDisable(ledDisable),
		.advPause(advPause), .advAbil1(advAbil1), .advAbil2(advAbil2)
	);

	mpr_mdio_master mst (
		.clk(clk), .mdc(mdc), .mdioDrv(drv), .mdioDrvOe(drvOe),
		.mdioWire(mdioWire)
	);

	// verdict and end of run
	task automatic testDone();
		if (failCount == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// one comparison, four-state exact
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failCount++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// management read with expected word
	task automatic mdRd(input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] exp);
		logic [15:0] rd;
		mst.frame(mpr_pkg::OP_READ, phy, ra, 16'h0000, rd);
		chk(rd, exp);
	endtask

	// management write; commit lands a few cycles after the last rise
	task automatic mdWr(input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd);
		logic [15:0] rd;
		mst.frame(mpr_pkg::OP_WRITE, phy, ra, wd, rd);
		repeat (4) @(negedge clk);
	endtask

	// byte map write, one cycle strobe
	task automatic mapWr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk);
		mapAddr = a;
		mapWrEn = 1'b1;
		mapWrData = d;
		@(negedge clk);
		mapWrEn = 1'b0;
	endtask

	// byte map read, data registered a cycle after the address
	task automatic mapRd(input logic [6:0] a, input logic [7:0] exp);
		@(negedge clk);
		mapAddr = a;
		repeat (2) @(negedge clk);
		chk({8'h00, mapRdData}, {8'h00, exp});
	endtask

	// a hang is cut short well past the expected run length
	initial begin
		#1000000;
		failCount++;
		testDone();
	end

	// main sequence
	initial begin
		int r;
		repeat (12) @(negedge clk);
		sysRst = 1'b0;
		repeat (4) @(negedge clk);
		// images after reset
		mdRd(5'h01, 5'h00, 16'h1000);
		mdRd(5'h01, 5'h01, 16'h7808);
		mdRd(5'h01, 5'h02, ID_HI);
		mdRd(5'h02, 5'h03, ID_LO);
		mdRd(5'h02, 5'h04, 16'h05e1);
		chk({4'h0, anEnable, advPause, advAbil1, advAbil2}, 16'h0fff);
		mapRd(7'h1c, 8'h9f);
		// status sources raised before any disable is set
		@(negedge clk);
		anDone = 2'h1;
		linkUp = 2'h1;
		fef = 1'b1;
		mdRd(5'h01, 5'h01, 16'h783c);
		mdRd(5'h01, 5'h05, 16'h04a0);
		mapRd(7'h1e, 8'h75);
		// status byte ignores writes
		mapWr(7'h1e, 8'h00);
		mapRd(7'h1e, 8'h75);
		mapRd(7'h1f, 8'h01);
		// every control bit written as one
		mdWr(5'h01, 5'h00, 16'hffff);
		mdRd(5'h01, 5'h00, 16'h391f);
		chk({force100, powerDown, fullDuplex, forceMdi, mdixDisable,
			txDisable, ledDisable, farEndDisable, sawRestart},
			16'h5557);
		mapRd(7'h1c, 8'hff);
		mapRd(7'h1d, 8'hde);
		// advertisement cleared, selector stays fixed
		mdWr(5'h01, 5'h04, 16'h0000);
		mdRd(5'h01, 5'h04, 16'h0001);
		chk({11'h000, advPause[0], advAbil1}, 16'h0000);
		mapRd(7'h1c, 8'he0);
		// port 2 configured through the byte map only
		mapWr(7'h2c, 8'h00);
		mapWr(7'h2d, 8'hff);
		mdRd(5'h02, 5'h00, 16'h081b);
		mdRd(5'h02, 5'h04, 16'h0001);
		chk({8'h00, anEnable, advPause, advAbil2}, 16'h0040);
		// unsupported registers: no answer, writes dropped
		for (r = 6; r < 32; r += 25) begin
			mdRd(5'h01, 5'(r), 16'hffff);
			mdWr(5'h01, 5'(r), 16'h0000);
		end
		// unassigned port addresses
		mdWr(5'h03, 5'h00, 16'h0000);
		mdWr(5'h00, 5'h00, 16'h0000);
		mdRd(5'h00, 5'h00, 16'hffff);
		mdRd(5'h01, 5'h00, 16'h391f);
		// center mode: only port 1, at its programmed address
		centerMode = 1'b1;
		mapWr(7'h40, 8'h05);
		mdRd(5'h05, 5'h02, ID_HI);
		mdRd(5'h01, 5'h02, 16'hffff);
		mdRd(5'h02, 5'h02, 16'hffff);
		testDone();
	end
endmodule
`default_nettype wire
